/* logic/boot_pkg.sv */
// constants for the boot loader and sideband pin block
// assumes a 32-bit apb slave port and a 25 MHz pclk
package boot_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_DW = 8;
  localparam int unsigned CFG_AW = 4;
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned EVT_W = 8;
  localparam int unsigned HW_EVT_W = 6;
  localparam int unsigned TEST_W = 6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 8'h40;
  localparam logic [1:0] CFG_WIN_SEL = 2'b01;

  // field positions
  localparam int unsigned CTRL_RELOAD_BIT = 0;
  localparam int unsigned EVT_LOAD_OK_BIT = 0;
  localparam int unsigned EVT_LOAD_FAIL_BIT = 1;
  localparam int unsigned EVT_HW_LSB = 2;

  // reset values
  localparam logic [EVT_W-1:0] INT_MASK_RST = 8'h00;
  localparam logic [EVT_W-1:0] INT_STAT_RST = 8'h00;
  localparam logic [DATA_W-1:0] PRDATA_RST = 32'h0000_0000;
  localparam logic [CFG_AW-1:0] CFG_LAST = 4'hF;

  // four-level strap as decoded by the pad
  localparam logic [1:0] STRAP_TEST_LO = 2'b00;
  localparam logic [1:0] STRAP_TEST_R = 2'b01;
  localparam logic [1:0] STRAP_FLOAT = 2'b10;
  localparam logic [1:0] STRAP_HIGH = 2'b11;

  typedef enum logic [4:0] {
    LD_IDLE = 5'b00001,
    LD_REQ = 5'b00010,
    LD_WAIT = 5'b00100,
    LD_OK = 5'b01000,
    LD_FAIL = 5'b10000
  } ld_state_t;
endpackage : boot_pkg

/* logic/cfg_wr_if.sv */
// write path from the eeprom loader into the configuration store
// assumes both ends sit on pclk
`timescale 1ns/10ps
`default_nettype none
interface cfg_wr_if;
  logic we;
  logic [boot_pkg::CFG_AW-1:0] addr;
  logic [boot_pkg::CFG_DW-1:0] data;
  modport src (output we, output addr, output data);
  modport mem (input we, input addr, input data);
endinterface : cfg_wr_if
`default_nettype wire

/* logic/cfg_mem.sv */
// configuration word store filled by the loader, read over apb
// assumes read address presented one cycle before data is used
`timescale 1ns/10ps
`default_nettype none
module cfg_mem (
  // clock
  input wire logic clk,
  // fill port
  cfg_wr_if.mem wr,
  // read port
  input wire logic [boot_pkg::CFG_AW-1:0] rd_addr,
  output logic [boot_pkg::CFG_DW-1:0] rd_data
);
  logic [boot_pkg::CFG_DW-1:0] mem_reg [boot_pkg::CFG_WORDS];

  // no reset: contents are only meaningful after a good load
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem_reg[wr.addr] <= wr.data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule : cfg_mem
`default_nettype wire

/* logic/eeprom_loader.sv */
// walks the configuration words out of the external eeprom
// assumes a serial-bus engine outside answering each read with ack or err
`timescale 1ns/10ps
`default_nettype none
module eeprom_loader (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_clr,
  // control
  input wire logic start,
  output logic busy,
  output logic load_ok,
  output logic ok_pulse,
  output logic fail_pulse,
  // eeprom read engine
  output logic rd_req,
  output logic [boot_pkg::CFG_AW-1:0] rd_addr,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [boot_pkg::CFG_DW-1:0] rd_data,
  // store fill
  cfg_wr_if.src wr
);
  boot_pkg::ld_state_t state_reg, state_next;
  logic [boot_pkg::CFG_AW-1:0] addr_reg;
  wire logic last_word = (addr_reg == boot_pkg::CFG_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      boot_pkg::LD_IDLE, boot_pkg::LD_OK, boot_pkg::LD_FAIL: begin
        if (start) state_next = boot_pkg::LD_REQ;
      end
      boot_pkg::LD_REQ: state_next = boot_pkg::LD_WAIT;
      boot_pkg::LD_WAIT: begin
        if (rd_err) state_next = boot_pkg::LD_FAIL;
        else if (rd_ack) state_next = last_word ? boot_pkg::LD_OK : boot_pkg::LD_REQ;
      end
      default: state_next = boot_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= boot_pkg::LD_IDLE;
      addr_reg <= '0;
      ok_pulse <= 1'b0;
      fail_pulse <= 1'b0;
      load_ok <= 1'b0;
    end else if (soft_clr) begin
      state_reg <= boot_pkg::LD_IDLE;
      addr_reg <= '0;
      ok_pulse <= 1'b0;
      fail_pulse <= 1'b0;
      load_ok <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) addr_reg <= '0;
      else if (state_reg == boot_pkg::LD_WAIT && rd_ack && !rd_err) addr_reg <= addr_reg + 1'b1;
      ok_pulse <= (state_next == boot_pkg::LD_OK) && (state_reg == boot_pkg::LD_WAIT);
      fail_pulse <= (state_next == boot_pkg::LD_FAIL) && (state_reg == boot_pkg::LD_WAIT);
      // only a full, error-free walk counts as loaded
      load_ok <= (state_next == boot_pkg::LD_OK);
    end
  end

  assign busy = (state_reg == boot_pkg::LD_REQ) || (state_reg == boot_pkg::LD_WAIT);
  assign rd_req = (state_reg == boot_pkg::LD_REQ);
  assign rd_addr = addr_reg;
  assign wr.we = (state_reg == boot_pkg::LD_WAIT) && rd_ack && !rd_err;
  assign wr.addr = addr_reg;
  assign wr.data = rd_data;
endmodule : eeprom_loader
`default_nettype wire

/* logic/boot_ctrl.sv */
// sideband pin block: eeprom boot request, completion pin, interrupt pin
// assumes all pins already synchronous to pclk and an apb master outside
// Overview of operation
// R1 - In master mode a low level on the read request pin starts the eeprom configuration load.
// R2 - In master mode the host may keep the read request pin low after completion with no further effect.
// R3 - In slave mode a low read request pin holds the bus engine and all registers in reset; the code does not reset the configuration store.
// R4 - In slave mode the host leaves the read request pin high or floating for normal operation.
// R5 - In master mode the completion pin is high on failed or unfinished loads and low only after a good one.
// R6 - In slave mode the completion pin follows the read request pin.
// R7 - The interrupt pin is pulled low while any enabled event is pending and released otherwise.
// R8 - Software chooses which events may raise the interrupt through a mask register.
// R9 - The interrupt pin only ever pulls low so many devices can share one pulled-up net.
// R10 - Factory test inputs are inputs only and never alter behaviour.
// R11 - The role strap gives master mode when floating, slave mode when high, and test otherwise.
// R12 - In master mode the completion pin stays high from reset until a load that was requested ends well.
`timescale 1ns/10ps
`default_nettype none
module boot_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [boot_pkg::ADDR_W-1:0] paddr,
  input wire logic [boot_pkg::DATA_W-1:0] pwdata,
  output logic [boot_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // sideband pins
  input wire logic read_req_n,
  input wire logic [1:0] bus_role_strap,
  output logic done_n,
  output logic int_n_out,
  output logic int_n_oe,
  // factory test inputs
  input wire logic factory_test_in_a,
  input wire logic factory_test_in_b,
  input wire logic factory_test_in_c,
  input wire logic factory_test_in_d,
  input wire logic factory_test_in_e,
  input wire logic factory_test_in_f,
  // events from the rest of the device
  input wire logic [boot_pkg::HW_EVT_W-1:0] hw_event,
  // serial bus engine side
  output logic smb_rst_n,
  output logic ee_rd_req,
  output logic [boot_pkg::CFG_AW-1:0] ee_rd_addr,
  input wire logic ee_rd_ack,
  input wire logic ee_rd_err,
  input wire logic [boot_pkg::CFG_DW-1:0] ee_rd_data
);
  cfg_wr_if fill ();

  logic [1:0] strap_reg;
  logic strap_valid_reg;
  logic req_d_reg;
  logic reload_reg;
  logic [boot_pkg::EVT_W-1:0] int_mask_reg;
  logic [boot_pkg::EVT_W-1:0] int_stat_reg;
  logic [boot_pkg::EVT_W-1:0] int_stat_next;
  logic [boot_pkg::TEST_W-1:0] test_reg;
  logic ok_seen_reg;
  logic ld_busy;
  logic ld_ok;
  logic ld_ok_pulse;
  logic ld_fail_pulse;
  logic [boot_pkg::CFG_DW-1:0] cfg_rd_data;
  logic [boot_pkg::DATA_W-1:0] rdata_mux;

  // strap decode
  wire logic master_mode = strap_valid_reg && (strap_reg == boot_pkg::STRAP_FLOAT); // R11
  wire logic slave_mode = strap_valid_reg && (strap_reg == boot_pkg::STRAP_HIGH); // R11
  // slave-mode reset hold
  wire logic soft_rst = slave_mode && !read_req_n; // R3

  // apb decode
  wire logic wait_ph = psel && penable && !pready;
  wire logic done_ph = psel && penable && pready;
  wire logic sel_ctrl = (paddr == boot_pkg::OFS_CTRL);
  wire logic sel_status = (paddr == boot_pkg::OFS_STATUS);
  wire logic sel_mask = (paddr == boot_pkg::OFS_INT_MASK);
  wire logic sel_stat = (paddr == boot_pkg::OFS_INT_STAT);
  wire logic sel_cfg = (paddr[7:6] == boot_pkg::CFG_WIN_SEL) && (paddr[1:0] == 2'b00);
  wire logic mapped = sel_ctrl || sel_status || sel_mask || sel_stat || sel_cfg;
  // registers ignore writes while held in slave reset
  wire logic wr_ok = done_ph && pwrite && mapped && !soft_rst;
  wire logic [boot_pkg::CFG_AW-1:0] cfg_idx = paddr[5:2];

  // load start: pin falling edge or the reload bit, so a held-low pin does nothing more
  wire logic req_fall = req_d_reg && !read_req_n; // R2
  wire logic start = master_mode && !ld_busy && (req_fall || reload_reg); // R1

  wire logic [boot_pkg::EVT_W-1:0] evt_in = {hw_event, ld_fail_pulse, ld_ok_pulse};
  wire logic [boot_pkg::EVT_W-1:0] w1c = (wr_ok && sel_stat) ? pwdata[7:0] : '0;
  wire logic int_pend = |(int_stat_reg & int_mask_reg); // R8
  wire logic [boot_pkg::TEST_W-1:0] test_bus = {factory_test_in_f, factory_test_in_e,
      factory_test_in_d, factory_test_in_c, factory_test_in_b, factory_test_in_a};

  // a new event beats a simultaneous clear
  assign int_stat_next = (int_stat_reg & ~w1c) | evt_in;

  always_comb begin
    rdata_mux = boot_pkg::PRDATA_RST;
    if (sel_ctrl) rdata_mux = boot_pkg::PRDATA_RST;
    else if (sel_status) rdata_mux = {16'h0000, 2'b00, test_reg, strap_reg,
        read_req_n, slave_mode, master_mode, ok_seen_reg, ld_ok, ld_busy};
    else if (sel_mask) rdata_mux = {24'h00_0000, int_mask_reg};
    else if (sel_stat) rdata_mux = {24'h00_0000, int_stat_reg};
    else if (sel_cfg) rdata_mux = {24'h00_0000, cfg_rd_data};
  end

  // strap caught once, on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= boot_pkg::STRAP_TEST_LO;
      strap_valid_reg <= 1'b0;
    end else if (!strap_valid_reg) begin
      strap_reg <= bus_role_strap; // R11
      strap_valid_reg <= 1'b1;
    end
  end

  // apb handshake: one wait state covers the store's read latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= boot_pkg::PRDATA_RST;
    end else begin
      pready <= wait_ph;
      pslverr <= wait_ph && !mapped;
      if (wait_ph && !pwrite) prdata <= rdata_mux;
    end
  end

  // software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= boot_pkg::INT_MASK_RST;
      int_stat_reg <= boot_pkg::INT_STAT_RST;
      reload_reg <= 1'b0;
    end else if (soft_rst) begin
      int_mask_reg <= boot_pkg::INT_MASK_RST; // R3
      int_stat_reg <= boot_pkg::INT_STAT_RST; // R3
      reload_reg <= 1'b0;
    end else begin
      if (wr_ok && sel_mask) int_mask_reg <= pwdata[7:0]; // R8
      int_stat_reg <= int_stat_next;
      reload_reg <= wr_ok && sel_ctrl && pwdata[boot_pkg::CTRL_RELOAD_BIT];
    end
  end

  // pin-side flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d_reg <= 1'b1;
      ok_seen_reg <= 1'b0;
      done_n <= 1'b1;
      int_n_out <= 1'b0;
      int_n_oe <= 1'b0;
      smb_rst_n <= 1'b0;
      test_reg <= '0;
    end else begin
      // edge detector idles high until the role is known
      req_d_reg <= strap_valid_reg ? read_req_n : 1'b1;
      ok_seen_reg <= ld_ok;
      if (master_mode) done_n <= !ld_ok; // R5 R12
      else if (slave_mode) done_n <= read_req_n; // R6
      else done_n <= 1'b1;
      int_n_out <= 1'b0; // R9
      int_n_oe <= int_pend; // R7
      // held until the role is known: no one-cycle release before a slave hold
      smb_rst_n <= strap_valid_reg && !soft_rst; // R3
      // status only; never fed into control
      test_reg <= test_bus; // R10
    end
  end

  eeprom_loader u_loader (
    .clk(pclk),
    .rst_n(presetn),
    .soft_clr(soft_rst),
    .start(start),
    .busy(ld_busy),
    .load_ok(ld_ok),
    .ok_pulse(ld_ok_pulse),
    .fail_pulse(ld_fail_pulse),
    .rd_req(ee_rd_req),
    .rd_addr(ee_rd_addr),
    .rd_ack(ee_rd_ack),
    .rd_err(ee_rd_err),
    .rd_data(ee_rd_data),
    .wr(fill.src)
  );

  cfg_mem u_mem (
    .clk(pclk),
    .wr(fill.mem),
    .rd_addr(cfg_idx),
    .rd_data(cfg_rd_data)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_load_start;
    master_mode && !ld_busy && req_fall |=> ld_busy ##1 ee_rd_req == 1'b0;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start"); // R1

  property p_held_low_quiet;
    master_mode && $past(master_mode) && !read_req_n && !$past(read_req_n) && !reload_reg
        && !ld_busy |=> !ld_busy;
  endproperty
  a_held_low_quiet: assert property (p_held_low_quiet) else $error("held request restarted"); // R2

  property p_slave_reset;
    soft_rst |=> !smb_rst_n && int_mask_reg == boot_pkg::INT_MASK_RST && !ld_busy;
  endproperty
  a_slave_reset: assert property (p_slave_reset) else $error("slave reset hold failed"); // R3

  property p_done_low_cause;
    master_mode && $fell(done_n) |-> $past(ld_ok);
  endproperty
  a_done_low_cause: assert property (p_done_low_cause) else $error("done low without load"); // R5

  property p_done_fail_high;
    master_mode && $past(master_mode) && ld_fail_pulse |=> ##1 done_n;
  endproperty
  a_done_fail_high: assert property (p_done_fail_high) else $error("done low after fail"); // R5

  property p_done_mirror;
    slave_mode && $past(slave_mode) |-> done_n == $past(read_req_n);
  endproperty
  a_done_mirror: assert property (p_done_mirror) else $error("done not mirroring request"); // R6

  property p_int_follow;
    int_pend |=> int_n_oe ##0 !int_n_out;
  endproperty
  a_int_follow: assert property (p_int_follow) else $error("interrupt not pulled"); // R7

  property p_int_cause;
    $rose(int_n_oe) |-> $past(int_pend);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt from masked event"); // R8

  property p_never_high;
    int_n_out == 1'b0;
  endproperty
  a_never_high: assert property (p_never_high) else $error("interrupt pin driven high"); // R9

  property p_strap_role;
    strap_valid_reg && $past(strap_valid_reg) |-> $stable(strap_reg)
        && (slave_mode == (strap_reg == boot_pkg::STRAP_HIGH))
        && (master_mode == (strap_reg == boot_pkg::STRAP_FLOAT));
  endproperty
  a_strap_role: assert property (p_strap_role) else $error("strap role wrong"); // R11

  property p_done_until_ok;
    master_mode && !ok_seen_reg && !ld_ok |=> done_n;
  endproperty
  a_done_until_ok: assert property (p_done_until_ok) else $error("done early"); // R12

  c_load_ok: cover property (master_mode && ld_ok_pulse ##2 !done_n);
  c_slave_hold: cover property (slave_mode && soft_rst ##1 !smb_rst_n);
  c_int_raise: cover property ($rose(int_n_oe));
  c_load_fail: cover property (master_mode && ld_fail_pulse);
endmodule : boot_ctrl
`default_nettype wire

/* sim/ee_engine_model.sv */
// behavioural serial-bus read engine facing the boot loader
// assumes requests are one-cycle pulses on the rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module ee_engine_model (
  // clock and engine reset
  input wire logic clk,
  input wire logic rst_n,
  // request side
  input wire logic req,
  input wire logic [3:0] addr,
  input wire logic [4:0] fail_at,
  // answer side
  output logic ack,
  output logic err,
  output logic [7:0] data
);
  int wait_cnt = 0;
  logic [3:0] cur = 4'h0;

  initial begin
    ack = 1'b0;
    err = 1'b0;
    data = 8'h00;
  end

  // odd words answer slowly; data toggles outside an answer so stale bytes show
  always @(posedge clk) begin
    ack <= 1'b0;
    err <= 1'b0;
    data <= ~data;
    if (!rst_n) begin
      wait_cnt <= 0;
    end else if (req) begin
      cur <= addr;
      wait_cnt <= addr[0] ? 3 : 1;
    end else if (wait_cnt == 1) begin
      ack <= ({1'b0, cur} != fail_at);
      err <= ({1'b0, cur} == fail_at);
      data <= {cur, ~cur};
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : ee_engine_model
`default_nettype wire

/* sim/test_boot_ctrl.sv */
// self-checking bench for the boot request, completion and interrupt pins
// assumes the engine model answers every loader read
`timescale 1ns/10ps
`default_nettype none
module test_boot_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic read_req_n, done_n, int_n_out, int_n_oe, smb_rst_n, e;
  logic [1:0] bus_role_strap;
  logic [5:0] tst, hw_event;
  logic ee_rd_req, ee_rd_ack, ee_rd_err;
  logic [3:0] ee_rd_addr;
  logic [7:0] ee_rd_data;
  logic [4:0] fail_at;
  int n_mismatch = 0;
  int compares = 0;
  int n_req = 0;

  boot_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .read_req_n(read_req_n), .bus_role_strap(bus_role_strap),
    .done_n(done_n), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .factory_test_in_a(tst[0]), .factory_test_in_b(tst[1]), .factory_test_in_c(tst[2]),
    .factory_test_in_d(tst[3]), .factory_test_in_e(tst[4]), .factory_test_in_f(tst[5]),
    .hw_event(hw_event), .smb_rst_n(smb_rst_n), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_err(ee_rd_err),
    .ee_rd_data(ee_rd_data));

  ee_engine_model i_eng (.clk(pclk), .rst_n(smb_rst_n), .req(ee_rd_req),
    .addr(ee_rd_addr), .fail_at(fail_at), .ack(ee_rd_ack), .err(ee_rd_err),
    .data(ee_rd_data));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (ee_rd_req === 1'b1) begin
      n_req++;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
    check(32'(e), 32'(eexp));
  endtask : rd_chk

  task automatic wait_done(input logic v);
    int n;
    n = 0;
    while (done_n !== v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check(32'(done_n), 32'(v));
  endtask : wait_done

  task automatic rst(input logic [1:0] s);
    presetn <= 1'b0;
    bus_role_strap <= s;
    read_req_n <= 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // generous: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, read_req_n} = 5'b00001;
    {paddr, pwdata, bus_role_strap, tst, hw_event} = '0;
    fail_at = 5'h1F;
    @(posedge pclk);
    rst(boot_pkg::STRAP_FLOAT);
    check(32'(done_n), 32'h1);
    check(32'(int_n_oe), 32'h0);
    rd_chk(boot_pkg::OFS_INT_MASK, 32'h0, 1'b0);
    rd_chk(8'h20, 32'h0, 1'b1);
    $display("test reset done");
    read_req_n <= 1'b0;
    wait_done(1'b0);
    check(32'(n_req), 32'h10);
    for (int i = 0; i < 16; i++) begin
      rd_chk(boot_pkg::OFS_CFG_BASE + 8'(4 * i), {24'h0, 4'(i), ~4'(i)}, 1'b0);
    end
    rd_chk(boot_pkg::OFS_INT_STAT, 32'h1, 1'b0);
    repeat (20) @(posedge pclk);
    check(32'(done_n), 32'h0);
    check(32'(n_req), 32'h10);
    $display("test load done");
    check(32'(int_n_oe), 32'h0);
    apb(1'b1, boot_pkg::OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(int_n_oe), 32'h1);
    check(32'(int_n_out), 32'h0);
    apb(1'b1, boot_pkg::OFS_INT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(int_n_oe), 32'h0);
    apb(1'b1, boot_pkg::OFS_INT_MASK, 32'h4);
    hw_event <= 6'h01;
    @(posedge pclk);
    hw_event <= 6'h00;
    repeat (3) @(posedge pclk);
    check(32'(int_n_oe), 32'h1);
    rd_chk(boot_pkg::OFS_INT_STAT, 32'h4, 1'b0);
    apb(1'b1, boot_pkg::OFS_INT_STAT, 32'h4);
    $display("test interrupt done");
    fail_at <= 5'h05;
    apb(1'b1, boot_pkg::OFS_CTRL, 32'h1);
    // poll busy; a dead loader still ends this after a bounded count
    // busy seeded high so the first status read always happens
    r = 32'h0000_0001;
    for (int n = 0; n < 50 && r[0] !== 1'b0; n++) begin
      apb(1'b0, boot_pkg::OFS_STATUS, 32'h0);
    end
    check(32'(done_n), 32'h1);
    check(32'(n_req), 32'h16);
    rd_chk(boot_pkg::OFS_INT_STAT, 32'h2, 1'b0);
    $display("test fail done");
    tst <= 6'h2A;
    repeat (3) @(posedge pclk);
    check(32'(done_n), 32'h1);
    check(32'(int_n_oe), 32'h0);
    apb(1'b0, boot_pkg::OFS_STATUS, 32'h0);
    check({26'h0, r[13:8]}, 32'h2A);
    $display("test factory done");
    rst(boot_pkg::STRAP_HIGH);
    apb(1'b0, boot_pkg::OFS_STATUS, 32'h0);
    check(32'(r[4:3]), 32'h2);
    apb(1'b1, boot_pkg::OFS_INT_MASK, 32'hA5);
    rd_chk(boot_pkg::OFS_INT_MASK, 32'hA5, 1'b0);
    read_req_n <= 1'b0;
    repeat (3) @(posedge pclk);
    check(32'(done_n), 32'h0);
    check(32'(smb_rst_n), 32'h0);
    rd_chk(boot_pkg::OFS_INT_MASK, 32'h0, 1'b0);
    read_req_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check(32'(done_n), 32'h1);
    check(32'(smb_rst_n), 32'h1);
    $display("test slave done");
    rst(boot_pkg::STRAP_TEST_LO);
    read_req_n <= 1'b0;
    repeat (20) @(posedge pclk);
    check(32'(n_req), 32'h16);
    check(32'(done_n), 32'h1);
    $display("test strap done");
    summarize();
  end
endmodule : test_boot_ctrl
`default_nettype wire
